// file: bench/psrseq_properties.sv
// Checker for clear, select and transfer sequencing on the link.
`timescale 1ns/10ps
module psrseq_chk
  import psrseq_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RSTN,
  // Link
  input wire logic clear_n,
  input wire logic select_n,
  input wire logic xfer_req
);
  // ==========================================================================
  // Cycle counters
  // ==========================================================================
  logic [CNT_W-1:0] lo_r;
  logic [CNT_W-1:0] hi_r;
  logic [CNT_W-1:0] fl_r;
  logic             cq_r;

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      lo_r <= '0;
      hi_r <= '0;
      fl_r <= '0;
      cq_r <= 1'b0;
    end else begin
      cq_r <= clear_n;
      lo_r <= clear_n ? '0 : lo_r + 16'h0001;
      hi_r <= !clear_n ? '0 : (&hi_r ? hi_r : hi_r + 16'h0001);
      fl_r <= (cq_r && !clear_n) ? '0 : (&fl_r ? fl_r : fl_r + 16'h0001);
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);
  sequence clr_rise_s; $rose(clear_n); endsequence
  sequence sel_idle_s; select_n [*8]; endsequence

  pulse_width_a: assert property (clr_rise_s |-> lo_r >= 16'(PULSE_CYC))
    else $error("clear pulse too short");
  sel_in_clear_a: assert property (!clear_n |-> select_n)
    else $error("select during clear");
  fall_gap_a: assert property (fl_r < 16'(ASSERT_CYC) |-> select_n)
    else $error("select too soon after clear fall");
  release_gap_a: assert property (hi_r < 16'(RELEASE_CYC) |-> select_n)
    else $error("select too soon after clear rise");
  init_hold_a: assert property (hi_r < 16'(INIT_WAIT_CYC) |-> select_n)
    else $error("select during init wait");
  xfer_select_a: assert property (xfer_req |-> !select_n)
    else $error("transfer without select");
  xfer_clear_a: assert property (!clear_n |-> !xfer_req)
    else $error("transfer during clear");
  rise_idle_a: assert property (clr_rise_s |-> sel_idle_s)
    else $error("select right after clear rise");
endmodule // psrseq_chk

// file: bench/psrseq_tb.sv
// Testbench joining host and device ends through the link.
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_count++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module psram_init_and_hw_reset_tb;
  import psrseq_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        clk_sys, rst_n, clr_req, xfer_in, slp_req, deep_req, cfg_we, cfg_sel, wake_req;
  logic [15:0] cfg_wd, d_c0, d_c1;
  logic [12:0] d_row;
  logic        h_rdy, h_busy, h_rel, d_rdy, d_ref, d_val, d_slp, d_dp, d_acc;
  int          err_count = 0;
  int          checks = 0;

  psrseq_if lnk ();
  psrseq_host psrseq_host_i (.I_CLK_SYS(clk_sys), .I_RSTN(rst_n), .lnk(lnk),
    .I_CLEAR_REQ(clr_req), .I_XFER_REQ(xfer_in), .O_XFER_BUSY(h_busy),
    .O_READY(h_rdy), .O_RELOAD_NEEDED(h_rel));
  psrseq_dev psrseq_dev_i (.I_CLK_SYS(clk_sys), .I_RSTN(rst_n), .lnk(lnk),
    .I_SLEEP_REQ(slp_req), .I_DEEP_REQ(deep_req), .I_WAKE_REQ(wake_req),
    .I_CFG_WE(cfg_we), .I_CFG_SEL(cfg_sel), .I_CFG_WDATA(cfg_wd), .O_READY(d_rdy),
    .O_REFRESH_ON(d_ref), .O_ARRAY_VALID(d_val), .O_IN_SLEEP(d_slp),
    .O_IN_DEEP(d_dp), .O_CFG0(d_c0), .O_CFG1(d_c1), .O_REFRESH_ROW(d_row),
    .O_ACCESS_ACCEPT(d_acc));
  psrseq_chk psrseq_chk_i (.I_CLK_SYS(clk_sys), .I_RSTN(rst_n),
    .clear_n(lnk.clear_n), .select_n(lnk.select_n), .xfer_req(lnk.xfer_req));

  always #5 clk_sys = ~clk_sys;

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic end_sim;
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Follows one clear pulse and the init wait that comes after it.
  task automatic clr_phase;
    int n;
    for (n = 0; n < 40 && lnk.clear_n !== 1'b0; n++) tick(1);
    tick(1);
    `CHK("refresh", 1'b0, d_ref)
    `CHK("valid", 1'b0, d_val)
    `CHK("ready", 1'b0, d_rdy)
    `CHK("row", ROW_RST, d_row)
    `CHK("cfg0", CFG0_RST, d_c0)
    `CHK("cfg1", CFG1_RST, d_c1)
    `CHK("sleep", 1'b0, d_slp)
    `CHK("deep", 1'b0, d_dp)
    `CHK("reload", 1'b1, h_rel)
    `CHK("host ready low", 1'b0, h_rdy)
    `CHK("busy low", 1'b0, h_busy)
    for (n = 0; n < 40 && lnk.clear_n !== 1'b1; n++) tick(1);
    tick(2);
    `CHK("refresh on", 1'b1, d_ref)
    `CHK("row runs", ROW_RST + 13'h0001, d_row)
    for (n = 2; n < 16000 && d_rdy !== 1'b1; n++) tick(1);
    `CHK("init time", 1'b1, n <= INIT_WAIT_CYC)
    `CHK("valid", 1'b1, d_val)
    for (n = 0; n < 100 && h_rdy !== 1'b1; n++) tick(1);
    `CHK("host ready", 1'b1, h_rdy)
  endtask

  task automatic do_clear;
    clr_req = 1'b1;
    tick(1);
    clr_req = 1'b0;
    clr_phase();
  endtask

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    int n;
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {clr_req, xfer_in, slp_req, deep_req, cfg_we, cfg_sel, wake_req} = 7'h00;
    cfg_wd = 16'h1234;
    repeat (3) @(posedge clk_sys);
    tick(1);
    rst_n = 1'b1;
    clr_phase();
    xfer_in = 1'b1;
    tick(1);
    `CHK("busy", 1'b1, h_busy)
    xfer_in = 1'b0;
    for (n = 0; n < 6 && d_acc !== 1'b1; n++) tick(1);
    `CHK("accept", 1'b1, d_acc)
    tick(2);
    `CHK("reload", 1'b0, h_rel)
    cfg_we = 1'b1;
    tick(1);
    cfg_sel = 1'b1;
    cfg_wd = 16'h5678;
    tick(1);
    {cfg_we, cfg_sel} = 2'h0;
    tick(1);
    `CHK("cfg0 wr", 16'h1234, d_c0)
    `CHK("cfg1 wr", 16'h5678, d_c1)
    slp_req = 1'b1;
    tick(3);
    slp_req = 1'b0;
    `CHK("in sleep", 1'b1, d_slp)
    wake_req = 1'b1;
    tick(1);
    wake_req = 1'b0;
    tick(1);
    `CHK("woken", 1'b1, d_rdy)
    slp_req = 1'b1;
    tick(2);
    slp_req = 1'b0;
    `CHK("in sleep", 1'b1, d_slp)
    do_clear();
    deep_req = 1'b1;
    tick(3);
    deep_req = 1'b0;
    `CHK("in deep", 1'b1, d_dp)
    do_clear();
    deep_req = 1'b1;
    tick(2);
    deep_req = 1'b0;
    wake_req = 1'b1;
    tick(1);
    wake_req = 1'b0;
    tick(1);
    `CHK("deep left", 1'b0, d_dp)
    `CHK("deep valid", 1'b0, d_val)
    end_sim();
  end

  initial begin
    #700us;
    err_count++;
    end_sim();
  end
endmodule // psram_init_and_hw_reset_tb

// file: core/psrseq_cnt.sv
// Cycle counter with clear and a reached-limit flag.
`timescale 1ns/10ps
module psrseq_cnt
  import psrseq_pkg::*;
(
  // Clock and reset
  input  wire logic             I_CLK_SYS,
  input  wire logic             I_RSTN,
  // Control
  input  wire logic             i_clr,
  input  wire logic [CNT_W-1:0] i_limit,
  // Status
  output logic                  o_done
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } psrseq_cnt_st_type;

  psrseq_cnt_st_type st_r;
  psrseq_cnt_st_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (i_clr) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt < i_limit) begin
      st_nxt.cnt = psrseq_inc(st_r.cnt);
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_done = (st_r.cnt >= i_limit) && !i_clr;
endmodule // psrseq_cnt

// file: core/psrseq_dev.sv
// Memory device end: power-up init wait and hardware clear handling.
// Functional notes
// - Init wait at most 150 us.
// - Host keeps select high during init.
// - Low clear postpones init wait start.
// - Host issues no transfer during init.
// - Clear returns device to standby.
// - Clear restores configuration defaults.
// - Clear stops refresh, array invalid.
// - Clear exits hybrid sleep.
// - Clear exits deep power down.
// - Release resumes refresh, row counter reset.
// - Host: pulse 200 ns, 400 ns hold.
// - Host: 200 ns release to select.
// - Host treats data lost after clear.
`timescale 1ns/10ps
module psrseq_dev
  import psrseq_pkg::*;
(
  // Clock and reset
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RSTN,
  // Link
  psrseq_if.dev                  lnk,
  // Power state requests
  input  wire logic              I_SLEEP_REQ,
  input  wire logic              I_DEEP_REQ,
  input  wire logic              I_WAKE_REQ,
  // Configuration write
  input  wire logic              I_CFG_WE,
  input  wire logic              I_CFG_SEL,
  input  wire logic [CFG_W-1:0]  I_CFG_WDATA,
  // Status
  output logic                   O_READY,
  output logic                   O_REFRESH_ON,
  output logic                   O_ARRAY_VALID,
  output logic                   O_IN_SLEEP,
  output logic                   O_IN_DEEP,
  output logic [CFG_W-1:0]       O_CFG0,
  output logic [CFG_W-1:0]       O_CFG1,
  output logic [ROW_W-1:0]       O_REFRESH_ROW,
  output logic                   O_ACCESS_ACCEPT
);
  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    psrseq_dev_state_type st;
    logic [CFG_W-1:0]     cfg0;
    logic [CFG_W-1:0]     cfg1;
    logic [ROW_W-1:0]     row;
    logic                 valid;
    logic                 accept;
  } psrseq_dev_st_type;

  psrseq_dev_st_type s_r;
  psrseq_dev_st_type s_nxt;
  logic              init_done;
  logic              cnt_clr;
  logic              bus_idle;
  logic              want_deep;
  logic              want_sleep;
  logic              cfg0_wr;
  logic              cfg1_wr;
  logic              xfer_seen;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Next refresh row; the counter wraps at the top of the array.
  function automatic logic [ROW_W-1:0] row_step(input logic [ROW_W-1:0] row);
    row_step = ROW_W'(row + 1'b1);
  endfunction

  // States in which self-refresh runs.
  function automatic logic refresh_runs(input psrseq_dev_state_type st);
    refresh_runs = (st == DEV_INIT) || (st == DEV_STANDBY) || (st == DEV_SLEEP);
  endfunction

  // Power state that standby moves to for the pending request.
  function automatic psrseq_dev_state_type standby_next(input logic deep, input logic sleep);
    if (deep) begin
      standby_next = DEV_DEEP;
    end else if (sleep) begin
      standby_next = DEV_SLEEP;
    end else begin
      standby_next = DEV_STANDBY;
    end
  endfunction

  // ==========================================================================
  // Requests
  // ==========================================================================
  // Power states are entered only with the bus deselected; deep power down
  // wins over hybrid sleep, and both win over a configuration write.
  assign bus_idle   = lnk.select_n;
  assign want_deep  = bus_idle && I_DEEP_REQ;
  assign want_sleep = bus_idle && I_SLEEP_REQ && !I_DEEP_REQ;
  assign cfg0_wr    = I_CFG_WE && !I_CFG_SEL && !want_deep && !want_sleep;
  assign cfg1_wr    = I_CFG_WE && I_CFG_SEL && !want_deep && !want_sleep;

  // An access is taken only while selected with a transfer requested.
  assign xfer_seen  = !lnk.select_n && lnk.xfer_req;

  // ==========================================================================
  // Init wait counter
  // ==========================================================================
  // The count stops two short of the wait: one cycle goes to the clear state
  // and one to the done flag, so standby comes within the longest init time.
  assign cnt_clr = (s_r.st != DEV_INIT) || !lnk.clear_n;

  psrseq_cnt u_init_cnt (
    .I_CLK_SYS (I_CLK_SYS),
    .I_RSTN    (I_RSTN),
    .i_clr     (cnt_clr),
    .i_limit   (CNT_W'(INIT_WAIT_CYC - 2)),
    .o_done    (init_done)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  // A low clear input overrides every state; rows advance only while
  // self-refresh runs.
  always_comb begin
    s_nxt        = s_r;
    s_nxt.accept = 1'b0;
    if (refresh_runs(s_r.st)) begin
      s_nxt.row = row_step(s_r.row);
    end

    if (!lnk.clear_n) begin
      s_nxt.st    = DEV_CLEAR;
      s_nxt.cfg0  = CFG0_RST;
      s_nxt.cfg1  = CFG1_RST;
      s_nxt.row   = ROW_RST;
      s_nxt.valid = 1'b0;
    end else begin
      case (s_r.st)
        DEV_CLEAR: begin
          s_nxt.st = DEV_INIT;
        end
        DEV_INIT: begin
          if (init_done) begin
            s_nxt.st    = DEV_STANDBY;
            s_nxt.valid = 1'b1;
          end
        end
        DEV_STANDBY: begin
          s_nxt.accept = xfer_seen;
          s_nxt.st     = standby_next(want_deep, want_sleep);
          if (want_deep) begin
            s_nxt.valid = 1'b0;
          end
          if (cfg0_wr) begin
            s_nxt.cfg0 = I_CFG_WDATA;
          end
          if (cfg1_wr) begin
            s_nxt.cfg1 = I_CFG_WDATA;
          end
        end
        DEV_SLEEP: begin
          if (I_WAKE_REQ) begin
            s_nxt.st = DEV_STANDBY;
          end
        end
        DEV_DEEP: begin
          if (I_WAKE_REQ) begin
            s_nxt.st = DEV_CLEAR;
          end
        end
        default: begin
          s_nxt.st = DEV_CLEAR;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      s_r.st     <= DEV_CLEAR;
      s_r.cfg0   <= CFG0_RST;
      s_r.cfg1   <= CFG1_RST;
      s_r.row    <= ROW_RST;
      s_r.valid  <= 1'b0;
      s_r.accept <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Power state and array status.
  assign O_READY         = (s_r.st == DEV_STANDBY);
  assign O_REFRESH_ON    = refresh_runs(s_r.st);
  assign O_ARRAY_VALID   = s_r.valid;
  assign O_IN_SLEEP      = (s_r.st == DEV_SLEEP);
  assign O_IN_DEEP       = (s_r.st == DEV_DEEP);
  // Configuration, refresh position and access.
  assign O_CFG0          = s_r.cfg0;
  assign O_CFG1          = s_r.cfg1;
  assign O_REFRESH_ROW   = s_r.row;
  assign O_ACCESS_ACCEPT = s_r.accept;
endmodule // psrseq_dev

// file: core/psrseq_host.sv
// Host controller end: drives clear pulse and holds off selects.
`timescale 1ns/10ps
module psrseq_host
  import psrseq_pkg::*;
(
  // Clock and reset
  input  wire logic I_CLK_SYS,
  input  wire logic I_RSTN,
  // Link
  psrseq_if.host    lnk,
  // User side
  input  wire logic I_CLEAR_REQ,
  input  wire logic I_XFER_REQ,
  output logic      O_XFER_BUSY,
  output logic      O_READY,
  output logic      O_RELOAD_NEEDED
);
  typedef struct packed {
    psrseq_hst_state_type st;
    logic [CNT_W-1:0]     cnt;
    logic                 reload;
    logic                 sel_n;
    logic                 req;
  } psrseq_hst_st_type;

  psrseq_hst_st_type s_r;
  psrseq_hst_st_type s_nxt;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.cnt = psrseq_inc(s_r.cnt);
    case (s_r.st)
      HST_PULSE: begin
        s_nxt.sel_n = 1'b1;
        s_nxt.req   = 1'b0;
        if (s_r.cnt >= CNT_W'(PULSE_CYC - 1)) begin
          s_nxt.st  = HST_RELEASE;
          s_nxt.cnt = '0;
        end
      end
      HST_RELEASE: begin
        if (s_r.cnt >= CNT_W'(RELEASE_CYC - 1) && s_r.cnt >= CNT_W'(ASSERT_CYC - PULSE_CYC - 1)) begin
          s_nxt.st  = HST_INIT;
          s_nxt.cnt = '0;
        end
      end
      HST_INIT: begin
        if (s_r.cnt >= CNT_W'(INIT_WAIT_CYC)) begin
          s_nxt.st  = HST_READY;
          s_nxt.cnt = '0;
        end
      end
      HST_READY: begin
        s_nxt.cnt = s_r.cnt;
        if (I_CLEAR_REQ) begin
          s_nxt.st     = HST_PULSE;
          s_nxt.cnt    = '0;
          s_nxt.reload = 1'b1;
          s_nxt.sel_n  = 1'b1;
          s_nxt.req    = 1'b0;
        end else begin
          s_nxt.sel_n = !I_XFER_REQ;
          s_nxt.req   = I_XFER_REQ;
          if (I_XFER_REQ) begin
            s_nxt.reload = 1'b0;
          end
        end
      end
      default: begin
        s_nxt.st = HST_PULSE;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      s_r.st     <= HST_PULSE;
      s_r.cnt    <= '0;
      s_r.reload <= 1'b1;
      s_r.sel_n  <= 1'b1;
      s_r.req    <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lnk.clear_n     = (s_r.st != HST_PULSE);
  assign lnk.select_n    = s_r.sel_n;
  assign lnk.xfer_req    = s_r.req;
  assign O_XFER_BUSY     = !s_r.sel_n;
  assign O_READY         = (s_r.st == HST_READY);
  assign O_RELOAD_NEEDED = s_r.reload;
endmodule // psrseq_host

// file: core/psrseq_if.sv
// Interface joining the host controller end and the memory device end.
`timescale 1ns/10ps
interface psrseq_if;
  logic clear_n;
  logic select_n;
  logic xfer_req;

  modport host (output clear_n, output select_n, output xfer_req);
  modport dev  (input  clear_n, input  select_n, input  xfer_req);
endinterface // psrseq_if

// file: core/psrseq_pkg.sv
// Package with timing constants and state encodings for the init and clear sequencer.
package psrseq_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS              = 10;
  localparam int INIT_WAIT_TIME_US          = 150;
  localparam int CLEAR_PULSE_WIDTH_NS       = 200;
  localparam int CLEAR_RELEASE_TO_SELECT_NS = 200;
  localparam int CLEAR_ASSERT_TO_SELECT_NS  = 400;

  // Longest time rounds down, least times round up.
  localparam int INIT_WAIT_CYC     = (INIT_WAIT_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int PULSE_CYC         = (CLEAR_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_CYC       = (CLEAR_RELEASE_TO_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ASSERT_CYC        = (CLEAR_ASSERT_TO_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W             = 16;

  // ==========================================================================
  // Configuration and refresh defaults
  // ==========================================================================
  localparam int         CFG_W       = 16;
  localparam logic [15:0] CFG0_RST   = 16'h8f1f;
  localparam logic [15:0] CFG1_RST   = 16'h0002;
  localparam int         ROW_W       = 13;
  localparam logic [12:0] ROW_RST    = 13'h0000;

  // ==========================================================================
  // Device power states
  // ==========================================================================
  typedef enum logic [4:0] {
    DEV_CLEAR   = 5'b00001,
    DEV_INIT    = 5'b00010,
    DEV_STANDBY = 5'b00100,
    DEV_SLEEP   = 5'b01000,
    DEV_DEEP    = 5'b10000
  } psrseq_dev_state_type;

  // ==========================================================================
  // Host sequencing states
  // ==========================================================================
  typedef enum logic [3:0] {
    HST_PULSE   = 4'b0001,
    HST_RELEASE = 4'b0010,
    HST_INIT    = 4'b0100,
    HST_READY   = 4'b1000
  } psrseq_hst_state_type;

  // Saturating-free count step, cut to the counter width.
  function automatic logic [CNT_W-1:0] psrseq_inc(input logic [CNT_W-1:0] v);
    psrseq_inc = CNT_W'(v + 1'b1);
  endfunction

endpackage
